// ### alu_slice_defs.svh
// Constants for the ALU datapath slice
`ifndef ALU_SLICE_DEFS_SVH
`define ALU_SLICE_DEFS_SVH
// ----------------------------------------
// Opcode fields
// ----------------------------------------
`define OPW_INC1 7'h49
`define OPW_INC2 7'h4B
`define OPW_DEC1 7'h5F
`define OPW_ANDB 7'h60
`define OPW_ANDW 7'h61
`define OPW_ANDNB 7'h68
`define OPW_ANDNW 7'h69
`define OP_ANDLIT 4'h4
// ----------------------------------------
// Flag bit positions
// ----------------------------------------
`define ST_NB 3
`define ST_ZB 2
`define ST_C4 1
`define ST_C8 0
`define CC_N 3
`define CC_Z 2
`define CC_V 1
`define CC_C 0
// ----------------------------------------
// Register offsets and resets
// ----------------------------------------
`define OFF_CTRL 12'h000
`define OFF_FLAGS 12'h004
`define OFF_STATE 12'h008
`define RF_SEL 6'h01
`define CTRL_RST 1'b1
`define FLAGS_RST 4'h0
`endif

// ### alu_slice_pkg.sv
// Types shared by the ALU datapath slice
package alu_slice_pkg;
  // Decoded operation kinds
  typedef enum logic [3:0] {
    OPK_NONE, OPK_INC1, OPK_INC2, OPK_DEC1,
    OPK_ANDLIT, OPK_ANDB, OPK_ANDNB,
    OPK_ANDW, OPK_ANDNW
  } opk_type;
  // Sequencing phase
  typedef enum logic {ST_RUN, ST_SECOND} phase_type;
endpackage

// ### incdec_unit.sv
// Word increment and decrement adder
module incdec_unit
  import alu_slice_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire alu_slice_pkg::opk_type opk, // Operation
  input wire logic [WIDTH-1:0] operand, // Source word
  output logic [WIDTH-1:0] result, // Sum
  output logic half_carry, // Carry out of bit 3
  output logic carry_out, // Carry out of top
  output logic overflow // Signed overflow
);
  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (WIDTH < 5) begin : g_bad
    $error("incdec_unit WIDTH too small");
  end
  logic [WIDTH-1:0] addend; // Constant addend
  logic [WIDTH:0] sum; // Sum with carry
  logic [4:0] low; // Low nibble sum
  // ----------------------------------------
  // Adder
  // ----------------------------------------
  // Decrement adds all ones
  always_comb begin
    case (opk)
      OPK_INC2: addend = WIDTH'(2);
      OPK_DEC1: addend = '1;
      default: addend = WIDTH'(1);
    endcase
    sum = {1'b0, operand} + {1'b0, addend};
    low = {1'b0, operand[3:0]} + {1'b0, addend[3:0]};
    result = sum[WIDTH-1:0];
    half_carry = low[4];
    carry_out = sum[WIDTH];
    overflow = (operand[WIDTH-1] == addend[WIDTH-1]) &&
               (sum[WIDTH-1] != operand[WIDTH-1]);
  end
endmodule

// ### and_unit.sv
// AND and AND-complement logic unit
module and_unit #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] src, // Source operand
  input wire logic [WIDTH-1:0] dst, // Destination operand
  input wire logic invert, // Complement source
  input wire logic is_word, // Word width flags
  output logic [WIDTH-1:0] result, // Logic result
  output logic neg, // Result negative
  output logic zero // Result zero
);
  // ----------------------------------------
  // Elaboration check
  // ----------------------------------------
  if (WIDTH != 16) begin : g_bad
    $error("and_unit needs WIDTH 16");
  end
  // ----------------------------------------
  // Logic and flags
  // ----------------------------------------
  // Byte flags look at low byte only
  always_comb begin
    result = (invert ? ~src : src) & dst;
    if (is_word) begin
      neg = result[WIDTH-1];
      zero = (result == '0);
    end else begin
      neg = result[7];
      zero = (result[7:0] == 8'h00);
    end
  end
endmodule

// ### alu_slice.sv
// Increment, decrement and AND datapath slice
//
// Chosen here: the APB register port and the placing of the registers.
`include "alu_slice_defs.svh"
module alu_slice (
  input wire logic pclk, // Clock
  input wire logic presetn, // Async reset, low
  input wire logic ce, // Clock enable
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error
  input wire logic [15:0] instr, // Instruction word
  input wire logic instr_valid, // Instruction offered
  output logic instr_ready, // Instruction taken
  output logic instr_done, // Operation retired
  output logic [3:0] status_flags, // NB ZB C4 C8
  output logic [3:0] cond_codes // N Z V C
);
  import alu_slice_pkg::*;
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [15:0][7:0] regs; // Register file
    logic [3:0] stat; // Status flags
    logic [3:0] cc; // Condition codes
    logic exec_en; // Execution enable
    phase_type phase; // Second cycle
    logic [15:0] hold_src; // Held source
    logic [15:0] hold_dst; // Held destination
    logic [3:0] hold_a; // Held destination no
    logic hold_fv; // Held variant bit
    logic done; // Retire pulse
    logic [7:0] retired; // Retire count
    logic [31:0] rdata; // Read data
    logic slverr; // Unmapped access
  } alu_state_type;
  alu_state_type r; // Current state
  alu_state_type n; // Next state
  // ----------------------------------------
  // Functions
  // ----------------------------------------
  // Read pair idx+1:idx
  function automatic logic [15:0] pair_rd(
    input logic [15:0][7:0] rf,
    input logic [3:0] idx
  );
    logic [3:0] hi;
    hi = idx + 4'h1;
    return {rf[hi], rf[idx]};
  endfunction
  // Byte sign-extended to word
  function automatic logic [15:0] sext(
    input logic [7:0] b
  );
    return {{8{b[7]}}, b};
  endfunction
  // Opcode decode
  function automatic opk_type op_of(
    input logic [15:0] w
  );
    opk_type k;
    k = OPK_NONE;
    if (w[15:12] == `OP_ANDLIT) begin
      k = OPK_ANDLIT;
    end else begin
      case (w[15:9])
        `OPW_INC1: k = OPK_INC1;
        `OPW_INC2: k = OPK_INC2;
        `OPW_DEC1: k = OPK_DEC1;
        `OPW_ANDB: k = OPK_ANDB;
        `OPW_ANDNB: k = OPK_ANDNB;
        `OPW_ANDW: k = OPK_ANDW;
        `OPW_ANDNW: k = OPK_ANDNW;
        default: k = OPK_NONE;
      endcase
    end
    return k;
  endfunction
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  opk_type k; // Decoded kind
  logic [3:0] a; // Destination number
  logic [3:0] b; // Source number
  logic fv; // Flag variant
  logic fire; // Instruction taken
  logic arith; // Inc or dec
  logic [15:0] arith_src; // Arithmetic operand
  logic [15:0] sum; // Adder result
  logic co; // Carry out
  logic ov; // Overflow
  logic [15:0] lg_src; // Logic source
  logic [15:0] lg_dst; // Logic destination
  logic lg_inv; // Complement source
  logic lg_word; // Word logic
  logic [15:0] lg_res; // Logic result
  logic lg_neg; // Logic negative
  logic lg_zero; // Logic zero
  logic apb_setup; // Setup phase
  logic apb_wr; // Write takes effect
  logic [3:0] ridx; // Register window index
  assign k = op_of(instr);
  assign a = instr[3:0];
  assign b = instr[7:4];
  assign fv = instr[8];
  assign instr_ready = r.exec_en && (r.phase == ST_RUN);
  assign fire = ce && instr_valid && instr_ready;
  assign arith = (k == OPK_INC1) || (k == OPK_INC2) ||
                 (k == OPK_DEC1);
  // Odd source uses one byte, sign-extended
  assign arith_src = b[0] ? sext(r.regs[b]) : pair_rd(r.regs, b);
  assign apb_setup = psel && !penable;
  assign apb_wr = ce && psel && penable && pwrite;
  assign ridx = paddr[5:2];
  // ----------------------------------------
  // Units
  // ----------------------------------------
  incdec_unit #(.WIDTH(16)) u_incdec (
    .opk(k),
    .operand(arith_src),
    .result(sum),
    .half_carry(), // Word ops keep half carry
    .carry_out(co),
    .overflow(ov)
  );
  // Literal uses field 11:4 as source
  always_comb begin
    lg_inv = (k == OPK_ANDNB) || (k == OPK_ANDNW);
    lg_word = (k == OPK_ANDW) || (k == OPK_ANDNW);
    lg_dst = pair_rd(r.regs, a);
    if (k == OPK_ANDLIT) begin
      lg_src = {8'h00, instr[11:4]};
    end else begin
      lg_src = pair_rd(r.regs, b);
    end
  end
  and_unit #(.WIDTH(16)) u_and (
    .src(lg_src),
    .dst(lg_dst),
    .invert(lg_inv),
    .is_word(lg_word),
    .result(lg_res),
    .neg(lg_neg),
    .zero(lg_zero)
  );
  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    n = r;
    n.done = 1'b0;
    // Register reads latched in setup
    if (apb_setup) begin
      n.rdata = 32'h0000_0000;
      n.slverr = 1'b0;
      if (paddr[11:6] == `RF_SEL) begin
        n.rdata = {24'h00_0000, r.regs[ridx]};
      end else begin
        case (paddr)
          `OFF_CTRL: n.rdata = {31'h0, r.exec_en};
          `OFF_FLAGS: n.rdata = {24'h00_0000, r.stat, r.cc};
          `OFF_STATE: n.rdata = {23'h0, r.retired,
                                 r.phase == ST_SECOND};
          default: n.slverr = 1'b1;
        endcase
      end
    end
    // Register writes in access phase
    if (apb_wr) begin
      if (paddr[11:6] == `RF_SEL) begin
        n.regs[ridx] = pwdata[7:0];
      end else begin
        case (paddr)
          `OFF_CTRL: n.exec_en = pwdata[0];
          `OFF_FLAGS: begin
            n.stat = pwdata[7:4];
            n.cc = pwdata[3:0];
          end
          default: n.exec_en = r.exec_en;
        endcase
      end
    end
    // Second cycle of word AND-complement
    if (r.phase == ST_SECOND) begin
      {n.regs[r.hold_a + 4'h1], n.regs[r.hold_a]} =
        ~r.hold_src & r.hold_dst;
      n.stat[`ST_NB] = n.regs[r.hold_a + 4'h1][7];
      n.stat[`ST_ZB] = ((~r.hold_src & r.hold_dst) == 16'h0000);
      if (r.hold_fv) begin
        n.cc[`CC_N] = n.stat[`ST_NB];
        n.cc[`CC_Z] = n.stat[`ST_ZB];
        n.cc[`CC_V] = 1'b0;
      end
      n.phase = ST_RUN;
      n.done = 1'b1;
      n.retired = r.retired + 8'h01;
    end
    // Operation issue
    if (fire) begin
      n.done = 1'b1;
      n.retired = r.retired + 8'h01;
      if (arith) begin
        // Only destination pair written
        n.regs[a] = sum[7:0];
        n.regs[a + 4'h1] = sum[15:8];
        n.stat[`ST_NB] = sum[15];
        n.stat[`ST_ZB] = (sum == 16'h0000);
        n.stat[`ST_C8] = co;
        if (fv) begin
          n.cc[`CC_N] = sum[15];
          n.cc[`CC_Z] = (sum == 16'h0000);
          n.cc[`CC_V] = ov;
          // Decrement carry means borrow
          n.cc[`CC_C] = (k == OPK_DEC1) ? !co : co;
        end
      end else if (k == OPK_ANDNW) begin
        // Capture operands, write next cycle
        n.hold_src = lg_src;
        n.hold_dst = lg_dst;
        n.hold_a = a;
        n.hold_fv = fv;
        n.phase = ST_SECOND;
        n.done = 1'b0;
        n.retired = r.retired;
      end else if (k != OPK_NONE) begin
        // Byte or word AND result
        n.regs[a] = lg_res[7:0];
        if (lg_word) begin
          n.regs[a + 4'h1] = lg_res[15:8];
        end
        n.stat[`ST_NB] = lg_neg;
        n.stat[`ST_ZB] = lg_zero;
        if (fv && k != OPK_ANDLIT) begin
          n.cc[`CC_N] = lg_neg;
          n.cc[`CC_Z] = lg_zero;
          n.cc[`CC_V] = 1'b0;
        end
      end
    end
  end
  // ----------------------------------------
  // State register
  // ----------------------------------------
  // Clock enable freezes all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.exec_en <= `CTRL_RST;
      r.stat <= `FLAGS_RST;
      r.cc <= `FLAGS_RST;
      r.phase <= ST_RUN;
    end else if (ce) begin
      r <= n;
    end
  end
  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign prdata = r.rdata;
  assign pslverr = r.slverr;
  assign pready = 1'b1;
  assign instr_done = r.done;
  assign status_flags = r.stat;
  assign cond_codes = r.cc;
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic disjoint; // Source and destination apart
  assign disjoint = (b != a) && (b != a + 4'h1) && (b + 4'h1 != a);
  chk_inc_one_sum: assert property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_INC1 && !b[0] |=>
    pair_rd(r.regs, $past(a)) == $past(arith_src) + 16'h0001)
    else $error("word plus one wrong");
  chk_odd_sign_ext: assert property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_INC2 && b[0] |=>
    pair_rd(r.regs, $past(a)) == sext($past(r.regs[b])) + 16'h0002)
    else $error("odd source not sign-extended");
  chk_inc_two_sum: assert property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_INC2 && !b[0] |=>
    pair_rd(r.regs, $past(a)) == $past(pair_rd(r.regs, b)) + 16'h0002)
    else $error("word plus two wrong");
  chk_dec_one_sum: assert property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_DEC1 && !b[0] |=>
    pair_rd(r.regs, $past(a)) == $past(pair_rd(r.regs, b)) - 16'h0001)
    else $error("word minus one wrong");
  chk_src_kept: assert property (@(posedge pclk) disable iff (!presetn)
    fire && arith && disjoint && !apb_wr |=> pair_rd(r.regs, $past(b)) == $past(pair_rd(r.regs, b)))
    else $error("source pair changed");
  chk_half_keep: assert property (@(posedge pclk) disable iff (!presetn)
    fire && arith && !apb_wr |=> status_flags[`ST_C4] == $past(status_flags[`ST_C4]))
    else $error("half carry changed");
  chk_word_nz: assert property (@(posedge pclk) disable iff (!presetn)
    fire && arith |=> status_flags[`ST_NB] == pair_rd(r.regs, $past(a)) >> 15 &&
    status_flags[`ST_ZB] == (pair_rd(r.regs, $past(a)) == 16'h0000))
    else $error("word flags wrong");
  chk_dec_borrow: assert property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_DEC1 && fv |=> cond_codes[`CC_C] == ($past(arith_src) == 16'h0000))
    else $error("borrow flag wrong");
  chk_lit_cc_kept: assert property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_ANDLIT && !apb_wr |=> $stable(cond_codes))
    else $error("literal AND touched codes");
  chk_ncw_two_cycles: assert property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_ANDNW ##1 ce |-> !instr_ready && !instr_done ##1 instr_done)
    else $error("AND-complement word timing");
  chk_and_carry_kept: assert property (@(posedge pclk) disable iff (!presetn)
    fire && !arith && k != OPK_NONE && !apb_wr |=> $stable(status_flags[1:0]) &&
    $stable(cond_codes[`CC_C]))
    else $error("AND changed a carry");
  chk_and_byte_res: assert property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_ANDB |=> r.regs[$past(a)] == ($past(r.regs[b]) & $past(r.regs[a])))
    else $error("byte AND result wrong");
  chk_and_v_clear: assert property (@(posedge pclk) disable iff (!presetn)
    fire && fv && (k == OPK_ANDB || k == OPK_ANDNB || k == OPK_ANDW) |=> !cond_codes[`CC_V])
    else $error("AND variant left V set");
  chk_cc_follow: assert property (@(posedge pclk) disable iff (!presetn)
    fire && arith && fv |=> cond_codes[`CC_N] == status_flags[`ST_NB] &&
    cond_codes[`CC_Z] == status_flags[`ST_ZB] &&
    cond_codes[`CC_V] == ($past(arith_src[15]) != cond_codes[`CC_N] &&
    $past(arith_src[15]) == $past(k == OPK_DEC1)))
    else $error("variant codes wrong");
  cov_inc_flag: cover property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_INC1 && fv);
  cov_dec_odd: cover property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_DEC1 && b[0]);
  cov_ncw: cover property (@(posedge pclk) disable iff (!presetn)
    fire && k == OPK_ANDNW ##2 instr_done);
endmodule

// ### seq_model.sv
// Sequencer model that offers instruction words to the slice
// ----------------------------------------
// Instruction offer side
// ----------------------------------------
module seq_model (
  input wire logic pclk, // Clock
  input wire logic presetn, // Reset, low
  input wire logic instr_ready, // Word taken
  output logic [15:0] instr, // Word offered
  output logic instr_valid // Offer strobe
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle at time zero
  initial begin
    instr = 16'h0000;
    instr_valid = 1'h0;
  end
  // Offer one word and hold it until the slice takes it
  task automatic issue(input logic [15:0] w);
    logic rdy;
    wait (presetn === 1'h1);
    @(posedge pclk);
    instr <= w;
    instr_valid <= 1'h1;
    // Ready is read mid-cycle, as the slice will see it at the next edge
    do begin
      @(negedge pclk);
      rdy = instr_ready;
      @(posedge pclk);
    end while (rdy !== 1'h1);
    instr_valid <= 1'h0;
    // Word no longer qualified, so scramble it
    instr <= ~w;
  endtask
endmodule

// ### test_alu_slice.sv
// Self-checking bench for the ALU datapath slice
`include "alu_slice_defs.svh"
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %0t got %h want %h", $time, (g), (e)); end end
module test_alu_slice;
  timeunit 1ns;
  timeprecision 1ns;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, er; // Bus and control
  logic [11:0] paddr; // Bus address
  logic [31:0] pwdata, prdata, rd; // Bus data
  logic [15:0] instr; // Instruction word
  logic instr_valid, instr_ready, instr_done; // Instruction handshake
  logic [3:0] status_flags, cond_codes; // Flag outputs
  int err_total = 0, cmp_count = 0, cyc_total = 0, n_ops = 0; // Counters
  alu_slice dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .instr(instr),
    .instr_valid(instr_valid), .instr_ready(instr_ready), .instr_done(instr_done),
    .status_flags(status_flags), .cond_codes(cond_codes));
  seq_model u_seq (.pclk(pclk), .presetn(presetn), .instr_ready(instr_ready), .instr(instr),
    .instr_valid(instr_valid));
  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  always #25 pclk = ~pclk;
  // Cut the run short if it hangs
  always @(posedge pclk) begin
    cyc_total++;
    if (cyc_total == 5000) begin
      err_total++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Print the verdict and stop
  task automatic wrap_up();
    if (err_total == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // One bus transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    // The wait ends once pready reads 1; the bench timeout covers a hang
    do begin
      @(posedge pclk);
    end while (pready !== 1'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  // Read and compare
  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'h0, a, 32'h0);
    `CHK(rd, e)
  endtask
  // Byte address of a file register
  function automatic logic [11:0] ra(input logic [3:0] i);
    return 12'h040 + {6'h00, i, 2'h0};
  endfunction
  // Build an instruction word
  function automatic logic [15:0] mk(input logic [6:0] o, input logic f, input logic [3:0] b, input logic [3:0] a);
    return {o, f, b, a};
  endfunction
  // Load operands and flags, run one op, check result, source and flags
  task automatic run_op(input logic [15:0] iw, input logic [3:0] b, input logic [15:0] bv, input logic [3:0] a,
    input logic [15:0] av, input logic [7:0] fi, input logic [15:0] ea, input logic [7:0] ef, input int ec);
    int c;
    c = 1;
    apb(1'h1, ra(b), {24'h0, bv[7:0]});
    apb(1'h1, ra(b + 4'h1), {24'h0, bv[15:8]});
    apb(1'h1, ra(a), {24'h0, av[7:0]});
    apb(1'h1, ra(a + 4'h1), {24'h0, av[15:8]});
    apb(1'h1, `OFF_FLAGS, {24'h0, fi});
    u_seq.issue(iw);
    n_ops++;
    #1;
    `CHK(instr_ready, (ec == 2) ? 1'h0 : 1'h1)
    // Look at done once it has settled after each edge
    while (instr_done !== 1'h1 && c < 20) begin
      @(posedge pclk);
      #1;
      c++;
    end
    `CHK(c, ec)
    `CHK({status_flags, cond_codes}, ef)
    rchk(ra(a), {24'h0, ea[7:0]});
    rchk(ra(a + 4'h1), {24'h0, ea[15:8]});
    rchk(ra(b), {24'h0, bv[7:0]});
    rchk(ra(b + 4'h1), {24'h0, bv[15:8]});
    rchk(`OFF_FLAGS, {24'h0, ef});
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    ce = 1'h1;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (2) @(posedge pclk);
    presetn <= 1'h1;
    // Reset values, unmapped access, execution disable
    rchk(`OFF_CTRL, 32'h1);
    rchk(`OFF_FLAGS, 32'h0);
    rchk(`OFF_STATE, 32'h0);
    `CHK(er, 1'h0)
    `CHK(pready, 1'h1)
    rchk(12'h100, 32'h0);
    `CHK(er, 1'h1)
    apb(1'h1, `OFF_CTRL, 32'h0);
    #1;
    `CHK(instr_ready, 1'h0)
    apb(1'h1, `OFF_CTRL, 32'h1);
    // Frozen clock enable ignores a write
    ce <= 1'h0;
    apb(1'h1, `OFF_CTRL, 32'h0);
    ce <= 1'h1;
    rchk(`OFF_CTRL, 32'h1);
    // Arithmetic, flags in {NB,ZB,C4,C8,N,Z,V,C}
    run_op(mk(`OPW_INC1, 1'h1, 4'h4, 4'h6), 4'h4, 16'hFFFE, 4'h6, 16'h1234, 8'h20, 16'hFFFF, 8'hA8, 1);
    run_op(mk(`OPW_INC2, 1'h1, 4'h0, 4'h2), 4'h0, 16'hFFFF, 4'h2, 16'h0000, 8'h00, 16'h0001, 8'h11, 1);
    run_op(mk(`OPW_INC1, 1'h1, 4'hA, 4'hC), 4'hA, 16'h7FFF, 4'hC, 16'h0000, 8'h00, 16'h8000, 8'h8A, 1);
    run_op(mk(`OPW_DEC1, 1'h1, 4'h2, 4'h4), 4'h2, 16'h0000, 4'h4, 16'h0000, 8'h20, 16'hFFFF, 8'hA9, 1);
    run_op(mk(`OPW_DEC1, 1'h1, 4'h6, 4'h8), 4'h6, 16'h8000, 4'h8, 16'h0000, 8'h00, 16'h7FFF, 8'h12, 1);
    run_op(mk(`OPW_DEC1, 1'h1, 4'h6, 4'h8), 4'h6, 16'h0001, 4'h8, 16'hFFFF, 8'h00, 16'h0000, 8'h54, 1);
    run_op(mk(`OPW_INC1, 1'h0, 4'h5, 4'h8), 4'h5, 16'h0080, 4'h8, 16'h0000, 8'h0F, 16'hFF81, 8'h8F, 1);
    run_op(mk(`OPW_INC2, 1'h0, 4'h7, 4'hA), 4'h7, 16'h00FF, 4'hA, 16'h0000, 8'h00, 16'h0001, 8'h10, 1);
    // Logical
    run_op({`OP_ANDLIT, 8'h90, 4'h3}, 4'hA, 16'h0000, 4'h3, 16'h0081, 8'h3F, 16'h0080, 8'hBF, 1);
    run_op(mk(`OPW_ANDB, 1'h1, 4'h1, 4'h3), 4'h1, 16'h007E, 4'h3, 16'h5581, 8'h33, 16'h5500, 8'h75, 1);
    run_op(mk(`OPW_ANDNB, 1'h1, 4'h1, 4'h3), 4'h1, 16'h007E, 4'h3, 16'h0081, 8'h02, 16'h0081, 8'h88, 1);
    run_op(mk(`OPW_ANDW, 1'h1, 4'h4, 4'h6), 4'h4, 16'h00FF, 4'h6, 16'h0F80, 8'h32, 16'h0080, 8'h30, 1);
    run_op(mk(`OPW_ANDNW, 1'h1, 4'h4, 4'h6), 4'h4, 16'h7FFF, 4'h6, 16'hFFFF, 8'h01, 16'h8000, 8'h89, 2);
    run_op(mk(`OPW_ANDW, 1'h0, 4'h0, 4'h2), 4'h0, 16'hFFFF, 4'h2, 16'h0000, 8'h0F, 16'h0000, 8'h4F, 1);
    // Retired count and idle state
    rchk(`OFF_STATE, {23'h0, n_ops[7:0], 1'h0});
    wrap_up();
  end
endmodule
